// *** hdl/csrlm_sync2.sv ***
// two-flop synchroniser for one level from outside the clock domain
module csrlm_sync2 (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic d_in,
  output logic      q_out
);

  logic stage1_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage1_ff <= 1'b0;
      q_out     <= 1'b0;
    end else begin
      stage1_ff <= d_in;
      q_out     <= stage1_ff;
    end
  end

endmodule // csrlm_sync2

// *** hdl/csrlm_top.sv ***
// comparator set-reset latch, output multiplexers, result mirrors and timer gate select
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Added by the designer: the placing of the registers and register access over APB.
module csrlm_top (
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_B_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // comparator results and timer side
  input  wire logic        FIRST_COMPARATOR_RESULT_IN,
  input  wire logic        SECOND_COMPARATOR_RESULT_IN,
  input  wire logic        TIMER_PRESCALED_CLK_IN,
  input  wire logic        EXTERNAL_GATE_PIN_IN,
  // toward timer and port logic
  output logic             TIMER_GATE_OUT,
  output logic             SYNCED_SECOND_RESULT_OUT,
  output logic             FIRST_PIN_OUT,
  output logic             SECOND_PIN_OUT,
  output logic             LATCH_Q_OUT,
  output logic             FIRST_COMPARATOR_STATUS_OUT,
  output logic             SECOND_COMPARATOR_STATUS_OUT
);

  // ------------------------------------------------------------
  // input synchronisation
  // ------------------------------------------------------------
  csrlm_pkg::csrlm_results_type res_sync;
  logic                         tclk_sync;
  logic                         gate_pin_sync;

  csrlm_sync2 u_sync_first (
    .clk_in   (REF_CLK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     (FIRST_COMPARATOR_RESULT_IN),
    .q_out    (res_sync.first_result)
  );

  csrlm_sync2 u_sync_second (
    .clk_in   (REF_CLK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     (SECOND_COMPARATOR_RESULT_IN),
    .q_out    (res_sync.second_result)
  );

  csrlm_sync2 u_sync_tclk (
    .clk_in   (REF_CLK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     (TIMER_PRESCALED_CLK_IN),
    .q_out    (tclk_sync)
  );

  csrlm_sync2 u_sync_gate (
    .clk_in   (REF_CLK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     (EXTERNAL_GATE_PIN_IN),
    .q_out    (gate_pin_sync)
  );

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic       gate_source_select_ff;
  logic       second_result_sync_enable_ff;
  logic [1:0] latch_output_config_ff;
  logic       first_result_set_enable_ff;
  logic       second_result_reset_enable_ff;
  logic       set_pulse_trigger_ff;
  logic       reset_pulse_trigger_ff;
  logic       latch_q_ff;
  logic       tclk_prev_ff;
  logic       synced_second_ff;

  logic wr_access;
  logic rd_access;
  logic hit_gate;
  logic hit_latch;
  logic lane0_wr;

  assign wr_access = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd_access = PSEL_IN & ~PWRITE_IN;
  assign hit_gate  = (PADDR_IN == csrlm_pkg::GATE_CTRL_ADDR);
  assign hit_latch = (PADDR_IN == csrlm_pkg::LATCH_CTRL_ADDR);
  assign lane0_wr  = wr_access & PSTRB_IN[0];

  // zero wait state slave; unmapped addresses flag an error
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~(hit_gate | hit_latch);

  // ------------------------------------------------------------
  // gate control register
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      gate_source_select_ff        <= csrlm_pkg::GATE_SRC_SEL_RST;
      second_result_sync_enable_ff <= csrlm_pkg::SYNC_EN_RST;
    end else if (lane0_wr && hit_gate) begin
      // bits 5-2 have no storage, so writes there vanish
      gate_source_select_ff        <= PWDATA_IN[csrlm_pkg::GATE_SRC_SEL_POS];
      second_result_sync_enable_ff <= PWDATA_IN[csrlm_pkg::SYNC_EN_POS];
    end
  end

  // ------------------------------------------------------------
  // latch control register
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      latch_output_config_ff        <= csrlm_pkg::CFG_RST;
      first_result_set_enable_ff    <= 1'b0;
      second_result_reset_enable_ff <= 1'b0;
    end else if (lane0_wr && hit_latch) begin
      latch_output_config_ff        <= {PWDATA_IN[csrlm_pkg::CFG_HI_POS], PWDATA_IN[csrlm_pkg::CFG_LO_POS]};
      first_result_set_enable_ff    <= PWDATA_IN[csrlm_pkg::SET_EN_POS];
      second_result_reset_enable_ff <= PWDATA_IN[csrlm_pkg::RESET_EN_POS];
    end
  end

  // pulse bits: a one fires for exactly one cycle, then hardware clears; zero writes do nothing
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      set_pulse_trigger_ff   <= 1'b0;
      reset_pulse_trigger_ff <= 1'b0;
    end else begin
      set_pulse_trigger_ff   <= lane0_wr & hit_latch & PWDATA_IN[csrlm_pkg::SET_PULSE_POS];
      reset_pulse_trigger_ff <= lane0_wr & hit_latch & PWDATA_IN[csrlm_pkg::RESET_PULSE_POS];
    end
  end

  // ------------------------------------------------------------
  // set-reset latch
  // ------------------------------------------------------------
  logic latch_set;
  logic latch_reset;

  // inputs are active high; the latch ignores the timer clock entirely
  assign latch_set   = (res_sync.first_result & first_result_set_enable_ff) | set_pulse_trigger_ff;
  assign latch_reset = (res_sync.second_result & second_result_reset_enable_ff) | reset_pulse_trigger_ff;

  // a true clockless latch cannot live in this flow; state settles one ref cycle after its input
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      latch_q_ff <= csrlm_pkg::LATCH_RST;
    end else if (latch_reset) begin
      latch_q_ff <= 1'b0;
    end else if (latch_set) begin
      latch_q_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // second result synchronised to falling timer clock
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tclk_prev_ff     <= 1'b0;
      synced_second_ff <= 1'b0;
    end else begin
      tclk_prev_ff <= tclk_sync;
      // prescaled clock falling edge, so the timer count on its rising edge sees a settled value
      if (tclk_prev_ff && !tclk_sync) begin
        synced_second_ff <= res_sync.second_result;
      end
    end
  end

  logic synced_second;
  assign synced_second = second_result_sync_enable_ff ? synced_second_ff : res_sync.second_result;

  // ------------------------------------------------------------
  // output multiplexers and outputs
  // ------------------------------------------------------------
  csrlm_pkg::csrlm_pins_type pins;

  always_comb begin
    // selection does not look at any comparator enable
    pins.first_pin  = latch_output_config_ff[0] ? latch_q_ff : res_sync.first_result;
    pins.second_pin = latch_output_config_ff[1] ? ~latch_q_ff : res_sync.second_result;
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      FIRST_PIN_OUT                <= 1'b0;
      SECOND_PIN_OUT               <= 1'b0;
      LATCH_Q_OUT                  <= 1'b0;
      TIMER_GATE_OUT               <= 1'b0;
      SYNCED_SECOND_RESULT_OUT     <= 1'b0;
      FIRST_COMPARATOR_STATUS_OUT  <= 1'b0;
      SECOND_COMPARATOR_STATUS_OUT <= 1'b0;
    end else begin
      // pin enables and direction belong to the port logic outside
      FIRST_PIN_OUT                <= pins.first_pin;
      SECOND_PIN_OUT               <= pins.second_pin;
      LATCH_Q_OUT                  <= latch_q_ff;
      TIMER_GATE_OUT               <= gate_source_select_ff ? gate_pin_sync : synced_second;
      SYNCED_SECOND_RESULT_OUT     <= synced_second;
      FIRST_COMPARATOR_STATUS_OUT  <= res_sync.first_result;
      SECOND_COMPARATOR_STATUS_OUT <= res_sync.second_result;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_gate) begin
      nxt_rdata[csrlm_pkg::MIRROR_FIRST_POS]  = res_sync.first_result;
      nxt_rdata[csrlm_pkg::MIRROR_SECOND_POS] = res_sync.second_result;
      nxt_rdata[csrlm_pkg::GATE_SRC_SEL_POS]  = gate_source_select_ff;
      nxt_rdata[csrlm_pkg::SYNC_EN_POS]       = second_result_sync_enable_ff;
    end else if (hit_latch) begin
      nxt_rdata[csrlm_pkg::CFG_HI_POS]        = latch_output_config_ff[1];
      nxt_rdata[csrlm_pkg::CFG_LO_POS]        = latch_output_config_ff[0];
      nxt_rdata[csrlm_pkg::SET_EN_POS]        = first_result_set_enable_ff;
      nxt_rdata[csrlm_pkg::RESET_EN_POS]      = second_result_reset_enable_ff;
    end
  end

  // data captured in setup phase; reads have no side effect on comparator state
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (rd_access && !PENABLE_IN) begin
      PRDATA_OUT <= nxt_rdata;
    end
  end

endmodule // csrlm_top

// *** inc/csrlm_pkg.sv ***
// package: register map, field positions, reset values and carrier types for the comparator latch block
package csrlm_pkg;

  // ------------------------------------------------------------
  // register byte addresses on apb
  // ------------------------------------------------------------
  localparam logic [11:0] GATE_CTRL_ADDR  = 12'h000;
  localparam logic [11:0] LATCH_CTRL_ADDR = 12'h004;

  // ------------------------------------------------------------
  // comparator_two_gate_control fields
  // ------------------------------------------------------------
  localparam int MIRROR_FIRST_POS   = 7;
  localparam int MIRROR_SECOND_POS  = 6;
  localparam int GATE_SRC_SEL_POS   = 1;
  localparam int SYNC_EN_POS        = 0;
  localparam logic GATE_SRC_SEL_RST = 1'b1;
  localparam logic SYNC_EN_RST      = 1'b0;

  // ------------------------------------------------------------
  // set_reset_latch_control fields
  // ------------------------------------------------------------
  localparam int CFG_HI_POS         = 7;
  localparam int CFG_LO_POS         = 6;
  localparam int SET_EN_POS         = 5;
  localparam int RESET_EN_POS       = 4;
  localparam int SET_PULSE_POS      = 3;
  localparam int RESET_PULSE_POS    = 2;
  localparam logic [1:0] CFG_RST    = 2'h0;
  localparam logic LATCH_RST        = 1'b0;

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic first_result;
    logic second_result;
  } csrlm_results_type;

  typedef struct packed {
    logic first_pin;
    logic second_pin;
  } csrlm_pins_type;

endpackage

// *** verif/csrlm_assertions.sv ***
// checker: port-level assertions for the comparator latch block
module csrlm_checker (
  input wire logic        REF_CLK_IN,
  input wire logic        RST_B_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        EXTERNAL_GATE_PIN_IN,
  input wire logic        TIMER_PRESCALED_CLK_IN,
  input wire logic        TIMER_GATE_OUT,
  input wire logic        SYNCED_SECOND_RESULT_OUT,
  input wire logic        FIRST_PIN_OUT,
  input wire logic        SECOND_PIN_OUT,
  input wire logic        LATCH_Q_OUT,
  input wire logic        FIRST_COMPARATOR_STATUS_OUT,
  input wire logic        SECOND_COMPARATOR_STATUS_OUT
);
  // ------------------------------------------------------------
  // shadow of written controls; warm masks sync-pipeline fill
  // ------------------------------------------------------------
  logic [7:0] gate_ff;
  logic [7:0] latch_ff;
  logic [2:0] warm_ff;
  wire        wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  wire        rd = PSEL_IN & PENABLE_IN & !PWRITE_IN;
  wire        ok = warm_ff == 3'h7;
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      gate_ff  <= 8'h02;
      latch_ff <= 8'h00;
    end else if (wr && PADDR_IN == csrlm_pkg::GATE_CTRL_ADDR) begin
      gate_ff  <= PWDATA_IN[7:0];
    end else if (wr && PADDR_IN == csrlm_pkg::LATCH_CTRL_ADDR) begin
      latch_ff <= PWDATA_IN[7:0];
    end
  end
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) warm_ff <= 3'h0;
    else if (!ok) warm_ff <= warm_ff + 3'h1;
  end
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  sync_bypass_a: assert property (ok && !gate_ff[0] && !$past(gate_ff[0])
    |-> SYNCED_SECOND_RESULT_OUT == SECOND_COMPARATOR_STATUS_OUT) else $error("sync bypass mismatch");
  sync_hold_a: assert property ((ok && gate_ff[0] && $stable(TIMER_PRESCALED_CLK_IN))[*6]
    |=> $stable(SYNCED_SECOND_RESULT_OUT)) else $error("synced result moved without timer edge");
  gate_sync_a: assert property ((ok && !gate_ff[1] && $stable(SYNCED_SECOND_RESULT_OUT))[*3]
    |-> TIMER_GATE_OUT == SYNCED_SECOND_RESULT_OUT) else $error("gate not synced result");
  gate_pin_a: assert property ((ok && gate_ff[1] && $stable(EXTERNAL_GATE_PIN_IN))[*5]
    |-> TIMER_GATE_OUT == EXTERNAL_GATE_PIN_IN) else $error("gate not external pin");
  cfg_plain_a: assert property (ok && latch_ff[7:6] == 2'h0 && $past(latch_ff[7:6]) == 2'h0
    |-> FIRST_PIN_OUT == FIRST_COMPARATOR_STATUS_OUT && SECOND_PIN_OUT == SECOND_COMPARATOR_STATUS_OUT)
    else $error("plain pins wrong");
  cfg_latch_a: assert property (ok && latch_ff[7:6] == 2'h3 && $past(latch_ff[7:6]) == 2'h3
    |-> FIRST_PIN_OUT == LATCH_Q_OUT && SECOND_PIN_OUT == !LATCH_Q_OUT) else $error("latch pins wrong");
  reset_wins_a: assert property (ok && $past(latch_ff[4], 2) && $past(SECOND_COMPARATOR_STATUS_OUT)
    |-> !LATCH_Q_OUT) else $error("latch not reset");
  set_path_a: assert property (ok && $past(latch_ff[5], 2) && $past(FIRST_COMPARATOR_STATUS_OUT)
    && !$past(SECOND_COMPARATOR_STATUS_OUT) && !$past(latch_ff[2], 2) |-> LATCH_Q_OUT) else $error("latch not set");
  mirror_read_a: assert property (ok && rd && PADDR_IN == csrlm_pkg::GATE_CTRL_ADDR |-> PRDATA_OUT[7:0] ==
    {FIRST_COMPARATOR_STATUS_OUT, SECOND_COMPARATOR_STATUS_OUT, 4'h0, gate_ff[1:0]}) else $error("gate read wrong");
  pulse_read_a: assert property (rd && PADDR_IN == csrlm_pkg::LATCH_CTRL_ADDR
    |-> PRDATA_OUT == {24'h0, latch_ff[7:4], 4'h0}) else $error("latch read wrong");
endmodule // csrlm_checker

// *** verif/csrlm_far_model.sv ***
// far-side model: comparator results and a prescaled timer clock
module csrlm_far_model (
  input  wire logic                     clk_in,
  input  wire csrlm_pkg::csrlm_results_type lvl_in,
  input  wire logic                     run_in,
  output csrlm_pkg::csrlm_results_type  res_out,
  output logic                          tmr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_ff = 2'h0;
  initial res_out = 2'h0;
  initial tmr_out = 1'h0;
  // pin direction and output enables are set by software in the port logic
  // timer clock stands still unless the bench lets it run
  always @(posedge clk_in) begin
    res_out <= lvl_in;
    div_ff  <= run_in ? div_ff + 2'h1 : 2'h0;
    if (run_in && div_ff == 2'h3) tmr_out <= !tmr_out;
  end
endmodule // csrlm_far_model

// *** verif/csrlm_tb_top.sv ***
// testbench: apb stimulus, far-side model and reference comparison
module csrlm_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        REF_CLK_IN = 1'h0;
  logic        RST_B_IN = 1'h0;
  logic        PSEL_IN = 1'h0;
  logic        PENABLE_IN = 1'h0;
  logic        PWRITE_IN = 1'h0;
  logic        EXTERNAL_GATE_PIN_IN = 1'h0;
  logic        run = 1'h0;
  logic [11:0] PADDR_IN = 12'h0;
  logic [31:0] PWDATA_IN = 32'h0;
  logic [3:0]  PSTRB_IN = 4'hF;
  logic [31:0] PRDATA_OUT, r, rd;
  logic        PREADY_OUT, PSLVERR_OUT, TIMER_GATE_OUT, SYNCED_SECOND_RESULT_OUT, FIRST_PIN_OUT, se;
  logic        SECOND_PIN_OUT, LATCH_Q_OUT, FIRST_COMPARATOR_STATUS_OUT, SECOND_COMPARATOR_STATUS_OUT;
  logic        TIMER_PRESCALED_CLK_IN;
  csrlm_pkg::csrlm_results_type lvl = 2'h0, res;
  wire         FIRST_COMPARATOR_RESULT_IN = res.first_result;
  wire         SECOND_COMPARATOR_RESULT_IN = res.second_result;
  int          fails = 0, compares = 0, cyc = 0, c1 = 0, c2 = 0, q = 0, cfg = 0, sen = 0, ren = 0;
  bit   [31:0] seed = 32'h5A28;
  int          pd[5] = '{8'hC8, 8'hC0, 8'hC4, 8'hC8, 8'hCC};
  int          pq[5] = '{1, 1, 0, 1, 0};
  csrlm_top dut (.*);
  csrlm_far_model far (.clk_in(REF_CLK_IN), .lvl_in(lvl), .run_in(run), .res_out(res), .tmr_out(TIMER_PRESCALED_CLK_IN));
  always #20 REF_CLK_IN = !REF_CLK_IN;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic void upd();
    q = (ren && c2) ? 0 : ((sen && c1) ? 1 : q);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    PSEL_IN   <= 1'h1;
    PWRITE_IN <= wr;
    PADDR_IN  <= a;
    PWDATA_IN <= d;
    @(posedge REF_CLK_IN);
    PENABLE_IN <= 1'h1;
    do @(posedge REF_CLK_IN); while (PREADY_OUT !== 1'h1);
    rd = PRDATA_OUT;
    se = PSLVERR_OUT;
    PSEL_IN    <= 1'h0;
    PENABLE_IN <= 1'h0;
    @(posedge REF_CLK_IN);
  endtask
  task automatic outs();
    upd();
    repeat (6) @(posedge REF_CLK_IN);
    chk(FIRST_COMPARATOR_STATUS_OUT, c1);
    chk(SECOND_COMPARATOR_STATUS_OUT, c2);
    chk(LATCH_Q_OUT, q);
    chk(FIRST_PIN_OUT, cfg[0] ? q : c1);
    chk(SECOND_PIN_OUT, cfg[1] ? !q : c2);
  endtask
  // ------------------------------------------------------------
  // hang guard: the run needs well under 3000 cycles
  // ------------------------------------------------------------
  always @(posedge REF_CLK_IN) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge REF_CLK_IN);
    RST_B_IN <= 1'h1;
    apb(1'h0, csrlm_pkg::GATE_CTRL_ADDR, 32'h0);
    chk(rd, 32'h2);
    apb(1'h0, csrlm_pkg::LATCH_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk(se, 1'h1);
    apb(1'h1, csrlm_pkg::GATE_CTRL_ADDR, 32'hFF);
    $display("reset and map test done");
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      if (i % 6 == 0) begin
        cfg = i / 6;
        sen = 1;
        ren = i >= 12;
        apb(1'h1, csrlm_pkg::LATCH_CTRL_ADDR, {cfg[1:0], sen[0], ren[0], 4'h0});
        upd();
      end
      lvl <= r[1:0];
      c1 = r[1];
      c2 = r[0];
      outs();
      apb(1'h0, csrlm_pkg::GATE_CTRL_ADDR, 32'h0);
      chk(rd, {c1[0], c2[0], 6'h3});
    end
    $display("latch config test done");
    sen = 0;
    ren = 0;
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, csrlm_pkg::LATCH_CTRL_ADDR, pd[i]);
      q = pq[i];
      outs();
      apb(1'h0, csrlm_pkg::LATCH_CTRL_ADDR, 32'h0);
      chk(rd, 32'hC0);
    end
    $display("pulse test done");
    apb(1'h1, csrlm_pkg::GATE_CTRL_ADDR, 32'h0);
    lvl <= 2'h1;
    c2 = 1;
    run <= 1'h1;
    repeat (24) @(posedge REF_CLK_IN);
    run <= 1'h0;
    repeat (8) @(posedge REF_CLK_IN);
    chk(SYNCED_SECOND_RESULT_OUT, c2);
    chk(TIMER_GATE_OUT, c2);
    apb(1'h1, csrlm_pkg::GATE_CTRL_ADDR, 32'h1);
    lvl <= 2'h0;
    repeat (8) @(posedge REF_CLK_IN);
    chk(SYNCED_SECOND_RESULT_OUT, 1'h1);
    run <= 1'h1;
    repeat (24) @(posedge REF_CLK_IN);
    run <= 1'h0;
    repeat (8) @(posedge REF_CLK_IN);
    chk(SYNCED_SECOND_RESULT_OUT, 1'h0);
    apb(1'h1, csrlm_pkg::GATE_CTRL_ADDR, 32'h2);
    EXTERNAL_GATE_PIN_IN <= 1'h1;
    repeat (8) @(posedge REF_CLK_IN);
    chk(TIMER_GATE_OUT, 1'h1);
    $display("gate test done");
    conclude();
  end
endmodule // csrlm_tb_top
bind csrlm_top csrlm_checker chk_u (.*);
